// ===== two_wire_master_transmit_ctrl.sv
// Master transmit sequencer with control, data and status registers.
// Assumes open-drain pins resolved outside; oe_n low pulls the line low.
`timescale 1ns/1ps
module two_wire_master_transmit_ctrl
	import two_wire_pkg::*;
#(
	parameter int QUARTER = QUARTER_CYCLES
) (
	input wire logic clock,
	input wire logic srst,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DATA_W-1:0] reg_rdata,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe_n,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n
);

	// ****************************************
	// Declarations
	// ****************************************
	seq_state_t state_reg;
	role_t role_reg;
	logic [1:0] phase_reg;
	logic [3:0] bit_cnt_reg;
	logic [7:0] shift_reg;
	logic [7:0] data_reg;
	logic [7:0] status_reg;
	logic [7:0] rdata_reg;
	logic done_reg;
	logic ack_en_reg;
	logic sta_reg;
	logic sto_reg;
	logic wc_reg;
	logic en_reg;
	logic irq_en_reg;
	logic addr_phase_reg;
	logic acked_reg;
	logic scl_oe_n_reg;
	logic sda_oe_n_reg;
	logic tick;
	logic step;
	logic ctrl_wr;
	logic data_wr;
	logic stop_done;
	logic scl_s;
	logic sda_s;
	line_if lines ();

	// ****************************************
	// Helpers
	// ****************************************
	pin_sync #(
		.W(2)
	) u_sync (
		.clock(clock),
		.srst(srst),
		.pin({sda_i, scl_i}),
		.lines(lines)
	);

	bit_timer #(
		.QUARTER(QUARTER)
	) u_timer (
		.clock(clock),
		.srst(srst),
		.tick(tick)
	);

	assign scl_s = lines.scl;
	assign sda_s = lines.sda;

	// Clock-high phase waits for the line to be really high, honouring stretching
	assign step = tick && (phase_reg != 2'd2 || scl_s);
	assign ctrl_wr = reg_wr && (reg_addr == OFS_CONTROL);
	assign data_wr = reg_wr && (reg_addr == OFS_DATA);
	assign stop_done = en_reg && (state_reg == S_STOP) && (phase_reg == 2'd2) && step;

	// Lines are only ever pulled low, never driven high
	assign scl_o = 1'b0;
	assign sda_o = 1'b0;
	assign scl_oe_n = scl_oe_n_reg;
	assign sda_oe_n = sda_oe_n_reg;

	// ****************************************
	// Control register
	// ****************************************
	// Software write wins over the hardware clear of stop-request
	always_ff @(posedge clock) begin
		if (srst) begin
			ack_en_reg <= 1'b0;
			sta_reg <= 1'b0;
			sto_reg <= 1'b0;
			en_reg <= 1'b0;
			irq_en_reg <= 1'b0;
		end else begin
			if (stop_done) begin
				sto_reg <= 1'b0;
			end
			if (ctrl_wr) begin
				ack_en_reg <= reg_wdata[CTRL_ACK];
				sta_reg <= reg_wdata[CTRL_STA];
				sto_reg <= reg_wdata[CTRL_STO];
				en_reg <= reg_wdata[CTRL_EN];
				irq_en_reg <= reg_wdata[CTRL_IRQ];
			end
		end
	end

	// Write collision: dropped data write sets it, an accepted one clears it
	always_ff @(posedge clock) begin
		if (srst) begin
			wc_reg <= 1'b0;
		end else if (data_wr && !done_reg) begin
			wc_reg <= 1'b1;
		end else if (data_wr) begin
			wc_reg <= 1'b0;
		end
	end

	// ****************************************
	// Data register
	// ****************************************
	// Only taken while the done flag is set, so a byte in flight is never corrupted
	always_ff @(posedge clock) begin
		if (srst) begin
			data_reg <= DATA_RESET;
		end else if (data_wr && done_reg) begin
			data_reg <= reg_wdata;
		end
	end

	// ****************************************
	// Read port
	// ****************************************
	// Data valid in the cycle after the strobe only
	always_ff @(posedge clock) begin
		if (srst) begin
			rdata_reg <= '0;
		end else if (reg_rd) begin
			case (reg_addr)
				OFS_CONTROL: begin
					rdata_reg <= {done_reg, ack_en_reg, sta_reg, sto_reg, wc_reg, en_reg, 1'b0, irq_en_reg};
				end
				OFS_DATA: begin
					rdata_reg <= data_reg;
				end
				OFS_STATUS: begin
					rdata_reg <= status_reg & STATUS_MASK;
				end
				default: begin
					rdata_reg <= '0;
				end
			endcase
		end else begin
			rdata_reg <= '0;
		end
	end

	assign reg_rdata = rdata_reg;

	// ****************************************
	// Bus sequencer
	// ****************************************
	// Done clear comes first so a hardware set in the same cycle wins
	always_ff @(posedge clock) begin
		if (srst) begin
			state_reg <= S_IDLE;
			role_reg <= ROLE_NONE;
			phase_reg <= 2'd0;
			bit_cnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			status_reg <= STATUS_RESET;
			done_reg <= 1'b0;
			addr_phase_reg <= 1'b0;
			acked_reg <= 1'b0;
			scl_oe_n_reg <= 1'b1;
			sda_oe_n_reg <= 1'b1;
		end else begin
			if (ctrl_wr && reg_wdata[CTRL_DONE]) begin
				done_reg <= 1'b0;
			end
			if (!en_reg) begin
				// Disabled: let go of both lines at once
				state_reg <= S_IDLE;
				role_reg <= ROLE_NONE;
				phase_reg <= 2'd0;
				scl_oe_n_reg <= 1'b1;
				sda_oe_n_reg <= 1'b1;
			end else begin
				case (state_reg)
					S_IDLE: begin
						phase_reg <= 2'd0;
						if (sta_reg && !done_reg) begin
							state_reg <= S_WAIT_FREE;
						end
					end
					S_WAIT_FREE: begin
						// Both lines high at a tick counts as a free bus
						if (tick && scl_s && sda_s) begin
							state_reg <= S_START;
						end
					end
					S_START: begin
						if (step) begin
							if (phase_reg == 2'd0) begin
								sda_oe_n_reg <= 1'b0;
								phase_reg <= 2'd1;
							end else begin
								scl_oe_n_reg <= 1'b0;
								phase_reg <= 2'd0;
								done_reg <= 1'b1;
								status_reg <= ST_START;
								role_reg <= ROLE_NONE;
								state_reg <= S_HOLD;
							end
						end
					end
					S_HOLD: begin
						// Clock stays low while parked; resume once done is cleared, except in ROLE_MR with no start or stop requested
						scl_oe_n_reg <= 1'b0;
						phase_reg <= 2'd0;
						if (!done_reg) begin
							if (sto_reg) begin
								state_reg <= S_STOP;
							end else if (sta_reg) begin
								state_reg <= S_RSTART;
							end else if (role_reg != ROLE_MR) begin
								state_reg <= S_BYTE;
								shift_reg <= data_reg;
								bit_cnt_reg <= 4'h0;
								addr_phase_reg <= (role_reg == ROLE_NONE);
							end
						end
					end
					S_BYTE: begin
						if (step) begin
							case (phase_reg)
								2'd0: begin
									// MSB first; a one releases, a zero pulls low
									sda_oe_n_reg <= (bit_cnt_reg == ACK_SLOT) ? 1'b1 : shift_reg[7];
									phase_reg <= 2'd1;
								end
								2'd1: begin
									scl_oe_n_reg <= 1'b1;
									phase_reg <= 2'd2;
								end
								2'd2: begin
									phase_reg <= 2'd3;
									if (bit_cnt_reg == ACK_SLOT) begin
										acked_reg <= !sda_s;
									end else if (shift_reg[7] && !sda_s) begin
										// Another master won the line; back off completely
										scl_oe_n_reg <= 1'b1;
										sda_oe_n_reg <= 1'b1;
										status_reg <= ST_ARB_LOST;
										done_reg <= 1'b1;
										role_reg <= ROLE_NONE;
										phase_reg <= 2'd0;
										state_reg <= S_IDLE;
									end
								end
								default: begin
									scl_oe_n_reg <= 1'b0;
									phase_reg <= 2'd0;
									if (bit_cnt_reg == ACK_SLOT) begin
										done_reg <= 1'b1;
										state_reg <= S_HOLD;
										if (addr_phase_reg) begin
											status_reg <= acked_reg ? ST_ADDR_ACK : ST_ADDR_NACK;
											role_reg <= data_reg[0] ? ROLE_MR : ROLE_MT;
										end else begin
											status_reg <= acked_reg ? ST_DATA_ACK : ST_DATA_NACK;
										end
									end else begin
										bit_cnt_reg <= bit_cnt_reg + 4'h1;
										shift_reg <= {shift_reg[6:0], 1'b0};
									end
								end
							endcase
						end
					end
					S_RSTART: begin
						if (step) begin
							case (phase_reg)
								2'd0: begin
									sda_oe_n_reg <= 1'b1;
									phase_reg <= 2'd1;
								end
								2'd1: begin
									scl_oe_n_reg <= 1'b1;
									phase_reg <= 2'd2;
								end
								2'd2: begin
									sda_oe_n_reg <= 1'b0;
									phase_reg <= 2'd3;
								end
								default: begin
									scl_oe_n_reg <= 1'b0;
									phase_reg <= 2'd0;
									done_reg <= 1'b1;
									status_reg <= ST_RSTART;
									role_reg <= ROLE_NONE;
									state_reg <= S_HOLD;
								end
							endcase
						end
					end
					S_STOP: begin
						if (step) begin
							case (phase_reg)
								2'd0: begin
									sda_oe_n_reg <= 1'b0;
									phase_reg <= 2'd1;
								end
								2'd1: begin
									scl_oe_n_reg <= 1'b1;
									phase_reg <= 2'd2;
								end
								default: begin
									// Data rises with clock high; no done flag follows
									sda_oe_n_reg <= 1'b1;
									phase_reg <= 2'd0;
									role_reg <= ROLE_NONE;
									state_reg <= S_IDLE;
								end
							endcase
						end
					end
					default: begin
						state_reg <= S_IDLE;
					end
				endcase
			end
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);

	a_hold_clock_low: assert property (state_reg == S_HOLD |-> !scl_oe_n_reg)
		else $error("clock line released while parked");
	a_start_status: assert property (state_reg == S_START ##1 state_reg == S_HOLD
		|-> done_reg && status_reg == ST_START)
		else $error("start did not report 0x08");
	a_stop_no_done: assert property (state_reg == S_STOP ##1 state_reg == S_IDLE |-> !done_reg)
		else $error("done set after stop");
	a_rstart_status: assert property (state_reg == S_RSTART ##1 state_reg == S_HOLD
		|-> status_reg == ST_RSTART && done_reg)
		else $error("repeated start did not report 0x10");
	a_collision_drop: assert property (data_wr && !done_reg |=> wc_reg && data_reg == $past(data_reg))
		else $error("data write while busy not dropped");
	a_done_clear: assert property (ctrl_wr && reg_wdata[CTRL_DONE] && state_reg == S_HOLD |=> !done_reg)
		else $error("done not cleared by write of one");
	a_parked_stays: assert property (state_reg == S_HOLD && done_reg && en_reg |=> state_reg == S_HOLD)
		else $error("bus moved while done set");
	a_disable_release: assert property (!en_reg |=> state_reg == S_IDLE && scl_oe_n_reg && sda_oe_n_reg)
		else $error("bus driven while disabled");
	a_addr_status: assert property (state_reg == S_BYTE && addr_phase_reg ##1 state_reg != S_BYTE
		|-> status_reg inside {ST_ADDR_ACK, ST_ADDR_NACK, ST_ARB_LOST})
		else $error("bad status after address");
	a_free_before_start: assert property ($rose(state_reg == S_START) |-> $past(scl_s) && $past(sda_s))
		else $error("start on a busy bus");

endmodule

// ===== two_wire_pkg.sv
// Shared constants and types for the two-wire master transmit controller.
// Assumes one 125 MHz system clock and an 8-bit register port.
package two_wire_pkg;

	// ****************************************
	// Register map and fields
	// ****************************************
	localparam int DATA_W = 8;
	localparam int ADDR_W = 2;
	localparam logic [1:0] OFS_CONTROL = 2'h0;
	localparam logic [1:0] OFS_DATA = 2'h1;
	localparam logic [1:0] OFS_STATUS = 2'h2;
	localparam int CTRL_DONE = 7;
	localparam int CTRL_ACK = 6;
	localparam int CTRL_STA = 5;
	localparam int CTRL_STO = 4;
	localparam int CTRL_WC = 3;
	localparam int CTRL_EN = 2;
	localparam int CTRL_IRQ = 0;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] STATUS_MASK = 8'hf8;

	// ****************************************
	// Status codes
	// ****************************************
	localparam logic [7:0] ST_START = 8'h08;
	localparam logic [7:0] ST_RSTART = 8'h10;
	localparam logic [7:0] ST_ADDR_ACK = 8'h18;
	localparam logic [7:0] ST_ADDR_NACK = 8'h20;
	localparam logic [7:0] ST_DATA_ACK = 8'h28;
	localparam logic [7:0] ST_DATA_NACK = 8'h30;
	localparam logic [7:0] ST_ARB_LOST = 8'h38;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 8;
	localparam int SCL_PERIOD_NS = 10000;
	localparam int QUARTER_CYCLES = (SCL_PERIOD_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] ACK_SLOT = 4'h8;

	typedef enum {S_IDLE, S_WAIT_FREE, S_START, S_HOLD, S_BYTE, S_RSTART, S_STOP} seq_state_t;
	typedef enum {ROLE_NONE, ROLE_MT, ROLE_MR} role_t;

endpackage

// ===== line_if.sv
// Carrier for the synchronised bus line levels.
// Assumes both ends run on the system clock.
`timescale 1ns/1ps
interface line_if;
	logic scl;
	logic sda;
	modport source (output scl, output sda);
	modport sink (input scl, input sda);
endinterface

// ===== pin_sync.sv
// Three-stage synchroniser for the two bus lines.
// Assumes raw pin levels from outside the clock domain.
`timescale 1ns/1ps
module pin_sync #(
	parameter int W = 2
) (
	input wire logic clock,
	input wire logic srst,
	input wire logic [W-1:0] pin,
	line_if.source lines
);
	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;
	logic [W-1:0] out_reg;

	// Level moves only when stages two and three agree
	always_ff @(posedge clock) begin
		if (srst) begin
			s1_reg <= '1;
			s2_reg <= '1;
			s3_reg <= '1;
			out_reg <= '1;
		end else begin
			s1_reg <= pin;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			out_reg <= (s2_reg == s3_reg) ? s3_reg : out_reg;
		end
	end

	assign lines.scl = out_reg[0];
	assign lines.sda = out_reg[W-1];
endmodule

// ===== bit_timer.sv
// Free running quarter-bit tick generator.
// Assumes the system clock; tick is a one-cycle pulse.
`timescale 1ns/1ps
module bit_timer #(
	parameter int QUARTER = 313
) (
	input wire logic clock,
	input wire logic srst,
	output logic tick
);
	localparam int CW = $clog2(QUARTER + 1);
	localparam logic [CW-1:0] LAST = CW'(QUARTER - 1);
	logic [CW-1:0] cnt_reg;

	// Wraps every QUARTER cycles
	always_ff @(posedge clock) begin
		if (srst) begin
			cnt_reg <= '0;
		end else if (cnt_reg == LAST) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_reg + 1'b1;
		end
	end

	assign tick = (cnt_reg == LAST);
endmodule

// ===== two_wire_slave_model.sv
// Behavioural slave receiver on the two bus wires.
// Assumes the bench resolves both wires with pull-ups.
`timescale 1ns/1ps
module two_wire_slave_model (
	input wire logic scl,
	input wire logic sda,
	input wire logic nack,
	input wire logic grab,
	input wire logic stretch,
	output logic scl_oe_n,
	output logic sda_oe_n,
	output logic [7:0] last_byte,
	output int bytes,
	output int starts,
	output int stops
);
	logic [7:0] shift_reg;
	logic ack_drive;
	logic scl_hold;
	int bit_cnt;
	// ****************************************
	// Framing
	// ****************************************
	initial begin
		shift_reg = 8'h00;
		last_byte = 8'h00;
		ack_drive = 1'b0;
		scl_hold = 1'b0;
		bit_cnt = 0;
		bytes = 0;
		starts = 0;
		stops = 0;
	end
	// Data edges while the clock is high frame a transfer
	always @(negedge sda) if (scl === 1'b1) begin
		starts++;
		bit_cnt = 0;
	end
	always @(posedge sda) if (scl === 1'b1) begin
		stops++;
		bit_cnt = 0;
	end
	// MSB first, sampled on the rising clock
	always @(posedge scl) if (bit_cnt < 8) begin
		shift_reg = {shift_reg[6:0], sda};
		bit_cnt++;
	end
	// Ack slot follows every byte until a stop or restart
	always @(negedge scl) begin
		if (bit_cnt == 8) begin
			last_byte = shift_reg;
			bytes++;
			ack_drive = !nack;
			bit_cnt = 9;
		end else if (bit_cnt == 9) begin
			ack_drive = 1'b0;
			bit_cnt = 0;
		end
	end
	// Slow answer: hold the clock low a while after each fall
	always @(negedge scl) if (stretch) begin
		scl_hold = 1'b1;
		#100 scl_hold = 1'b0;
	end
	// Released data line floats high by the pull-up; grab forces a lost arbitration
	assign sda_oe_n = !(ack_drive || grab);
	assign scl_oe_n = !scl_hold;
endmodule

// ===== tb.sv
// Self-checking bench for the master transmit controller.
// Assumes a short quarter-bit count and one slave on the wires.
`timescale 1ns/1ps
module tb;
	import two_wire_pkg::*;
	logic clock = 0;
	logic srst = 1;
	logic [ADDR_W-1:0] reg_addr = '0;
	logic [DATA_W-1:0] reg_wdata = '0;
	logic reg_wr = 0;
	logic reg_rd = 0;
	logic [DATA_W-1:0] reg_rdata;
	logic scl_oe_n, sda_oe_n, s_scl_oe_n, s_sda_oe_n;
	logic scl_o, sda_o;
	logic nack = 0, grab = 0, stretch = 0;
	logic [7:0] last_byte, v, b;
	int bytes, starts, stops, n;
	int miscompares = 0;
	int tests_run = 0;
	// ****************************************
	// Wires and instances
	// ****************************************
	// Open-drain: any low enable wins, else pull-up
	wire scl_w = (scl_oe_n === 1'b0 || s_scl_oe_n === 1'b0) ? 1'b0 : 1'b1;
	wire sda_w = (sda_oe_n === 1'b0 || s_sda_oe_n === 1'b0) ? 1'b0 : 1'b1;
	// Two cycles a quarter gives a 64 ns nominal bit; the clock-high phase still waits for the synced line
	two_wire_master_transmit_ctrl #(.QUARTER(2)) i_two_wire_master_transmit_ctrl (
		.clock(clock), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_i(scl_w),
		.scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n(sda_oe_n));
	two_wire_slave_model i_two_wire_slave_model (
		.scl(scl_w), .sda(sda_w), .nack(nack), .grab(grab), .stretch(stretch),
		.scl_oe_n(s_scl_oe_n), .sda_oe_n(s_sda_oe_n), .last_byte(last_byte),
		.bytes(bytes), .starts(starts), .stops(stops));
	initial forever #4 clock = ~clock;
	// ****************************************
	// Tasks
	// ****************************************
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [1:0] a, output logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		@(posedge clock);
		d = reg_rdata;
	endtask
	// Command, poll the done flag under a bound, compare masked status
	task automatic step(input logic [7:0] c, input logic [7:0] exp);
		logic [7:0] r;
		wr(OFS_CONTROL, c);
		r = 8'h00;
		for (int i = 0; i < 400 && r[CTRL_DONE] !== 1'b1; i++) rd(OFS_CONTROL, r);
		check(r & 8'h80, 8'h80);
		rd(OFS_STATUS, r);
		check(r & STATUS_MASK, exp);
	endtask
	task automatic send(input logic [7:0] d, input logic [7:0] exp);
		wr(OFS_DATA, d);
		step(8'h84, exp);
		check(last_byte, d);
	endtask
	// Both enables released and both drive levels low, so the lines can only be pulled down
	task automatic lines_free;
		check({4'h0, scl_o, sda_o, scl_oe_n, sda_oe_n}, 8'h03);
	endtask
	// Expected control readback: reserved reads zero, done and collision come from hardware
	function automatic logic [7:0] ctrl_view(input logic [7:0] w, input logic done, input logic wc);
		logic [7:0] r;
		r = w;
		r[CTRL_DONE] = done;
		r[CTRL_WC] = wc;
		r[1] = 1'b0;
		return r;
	endfunction
	task automatic final_report;
		$display("checks=%0d mismatches=%0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Whole run is a few thousand cycles
	initial begin
		#400000;
		miscompares++;
		final_report();
	end
	// ****************************************
	// Tests
	// ****************************************
	initial begin
		void'($urandom(49526));
		repeat (4) @(posedge clock);
		srst <= 1'b0;
		rd(OFS_CONTROL, v);
		check(v, 8'h00);
		rd(OFS_STATUS, v);
		check(v, STATUS_RESET);
		wr(2'h3, 8'hff);
		rd(2'h3, v);
		check(v, 8'h00);
		$display("test reset done");
		// Reserved and collision bits read zero; enable off keeps the bus idle
		wr(OFS_CONTROL, 8'h6b);
		repeat (100) @(posedge clock);
		rd(OFS_CONTROL, v);
		check(v, ctrl_view(8'h6b, 1'b0, 1'b0));
		lines_free();
		$display("test control bits done");
		// Data write with flag low is dropped
		wr(OFS_DATA, 8'h5a);
		rd(OFS_CONTROL, v);
		check(v & 8'h08, 8'h08);
		rd(OFS_DATA, v);
		check(v, DATA_RESET);
		$display("test collision done");
		step(8'ha4, ST_START);
		check(8'(starts), 8'h01);
		repeat (60) @(posedge clock);
		check({7'h00, scl_oe_n}, 8'h00);
		wr(OFS_CONTROL, 8'h04);
		repeat (60) @(posedge clock);
		rd(OFS_CONTROL, v);
		check(v & 8'h80, 8'h80);
		check(8'(bytes), 8'h00);
		b = 8'($urandom_range(127, 1)) << 1;
		send(b, ST_ADDR_ACK);
		rd(OFS_CONTROL, v);
		check(v & 8'h08, 8'h00);
		n = $urandom_range(4, 2);
		for (int i = 0; i < n; i++) begin
			stretch <= (i == 1);
			send(8'($urandom), ST_DATA_ACK);
		end
		stretch <= 1'b0;
		send(8'hff, ST_DATA_ACK);
		nack <= 1'b1;
		send(8'h00, ST_DATA_NACK);
		nack <= 1'b0;
		$display("test data bytes done");
		step(8'ha4, ST_RSTART);
		check(8'(starts), 8'h02);
		nack <= 1'b1;
		send(b | 8'h80, ST_ADDR_NACK);
		nack <= 1'b0;
		$display("test restart done");
		// Stops counted relative: the wires settling at time zero may look like one
		n = stops;
		wr(OFS_CONTROL, 8'h94);
		repeat (200) @(posedge clock);
		rd(OFS_CONTROL, v);
		check(v, ctrl_view(8'h84, 1'b0, 1'b0));
		check(8'(stops - n), 8'h01);
		lines_free();
		$display("test stop done");
		// Slave holds data low against a sent one
		step(8'ha4, ST_START);
		grab <= 1'b1;
		wr(OFS_DATA, 8'ha0);
		step(8'h84, ST_ARB_LOST);
		repeat (20) @(posedge clock);
		lines_free();
		grab <= 1'b0;
		$display("test arbitration done");
		// Stop and start requested together: STOP, then a fresh START once the bus is free
		step(8'ha4, ST_START);
		n = stops;
		step(8'hb4, ST_START);
		check(8'(stops - n), 8'h01);
		wr(OFS_CONTROL, 8'h94);
		repeat (200) @(posedge clock);
		lines_free();
		$display("test stop then start done");
		final_report();
	end
endmodule
